// ### inc/rtimer_pkg.sv
// constants for the reload timer with prescaler
// assumes a 32-bit ahb-lite register bus, one aligned word per register
package rtimer_pkg;
   localparam int DW = 8;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_OSCTRL = 8'h04;
   localparam logic [7:0] OFF_IOCTRL = 8'h08;
   localparam logic [7:0] OFF_MODE = 8'h0c;
   localparam logic [7:0] OFF_PRE = 8'h10;
   localparam logic [7:0] OFF_SEC = 8'h14;
   localparam logic [7:0] OFF_PRI = 8'h18;
   localparam logic [7:0] CNT_RST = 8'hff;
   // control register bits
   localparam int CTRL_START = 0;
   localparam int CTRL_STATUS = 1;
   localparam int CTRL_FSTOP = 2;
   // one-shot control bits
   localparam int OS_START = 0;
   localparam int OS_STOP = 1;
   localparam int OS_STATUS = 2;
   // io control bits
   localparam int IO_LEVEL = 0;
   localparam int IO_PORT_VAL = 1;
   localparam int IO_PORT_OE = 2;
   localparam int IO_TRIG_EN = 3;
   // mode register fields
   localparam int MODE_LO = 0;
   localparam int MODE_HI = 1;
   localparam int MODE_WRC = 3;
   localparam int SRC_LO = 4;
   localparam int SRC_HI = 5;
   localparam int SRC_CUT = 7;
   localparam logic [1:0] M_TIMER = 2'h0;
   localparam logic [1:0] M_WAVE = 2'h1;
   localparam logic [1:0] M_ONESHOT = 2'h2;
   localparam logic [1:0] M_WAIT = 2'h3;
   localparam logic [1:0] S_DIV1 = 2'h0;
   localparam logic [1:0] S_DIV8 = 2'h1;
   localparam logic [1:0] S_COMP = 2'h2;
   localparam logic [1:0] S_DIV2 = 2'h3;
   localparam logic [2:0] DIV8_LAST = 3'h7;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ### logic/reload_timer.sv
// reload timer: 8-bit down counter behind an 8-bit prescaler, ahb-lite regs
// assumes one bus master, companion underflow pulse on the same clock,
// external trigger pin asynchronous to hclk
// Operation
// - eight-bit timer fed by eight-bit prescaler
// - primary and secondary reloads used alternately
// - one-shot control only in one-shot modes
// - forced stop resets values, start, flags
// - forced stop loads ffh into secondary, primary
// - status means counting, or one-shot trigger accepted
// - primary reads current count in secondary period
// - timer counts peripheral clocks or companion underflow
// - timer underflow reloads primary, keeps counting
// - underflow rate is source over (n+1)(m+1)
// - writing start one begins counting
// - start zero or forced stop halts counting
// - interrupt request on timer underflow: all in timer mode, secondary in wave, primary in one-shot
// - timer mode ignores one-shot, secondary; pin is port
// - primary and prescaler reads return counters
// - writes while stopped load reload and counter
// - running writes obey write-control bit
// - written value reaches counter on next step
`timescale 1ns/1ns
module reload_timer (
   input wire logic hclk, // bus clock, 125 mhz
   input wire logic hresetn, // async reset, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // word only
   input wire logic hready, // bus ready in
   input wire logic [31:0] hwdata, // write data
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   input wire logic ra_underflow, // companion timer underflow pulse
   input wire logic external_trigger_pin, // one-shot trigger, async
   output logic timer_output_pin_o, // output level
   output logic timer_output_pin_oe, // output enable
   output logic timer_irq // one-cycle interrupt request
);
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   logic start_r, status_r, os_active_r, sec_phase_r;
   logic [7:0] io_r, mode_r, pre_rl_r, sec_rl_r, pri_rl_r;
   logic [7:0] pre_cnt_r, tmr_cnt_r;
   logic pre_pend_r, tmr_pend_r;
   logic [2:0] div_r;
   logic [2:0] trig_sync_r;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic irq_r, out_o_r, out_oe_r;
   logic [31:0] rdata_r;

   logic [1:0] op_mode;
   logic [1:0] src_sel;
   logic os_mode, wave_mode, timer_mode;
   logic addr_ok, wr_now;
   logic [7:0] wd;
   logic fstop, wr_ctrl, wr_os, wr_pre, wr_sec, wr_pri;
   logic src_tick, run, pre_uf, tmr_uf, trig, os_stop;

   assign op_mode = {mode_r[rtimer_pkg::MODE_HI],
                     mode_r[rtimer_pkg::MODE_LO]};
   assign src_sel = {mode_r[rtimer_pkg::SRC_HI], mode_r[rtimer_pkg::SRC_LO]};
   assign timer_mode = (op_mode == rtimer_pkg::M_TIMER);
   assign wave_mode = (op_mode == rtimer_pkg::M_WAVE);
   assign os_mode = (op_mode == rtimer_pkg::M_ONESHOT) ||
                    (op_mode == rtimer_pkg::M_WAIT);

   // bus decode: address phase captured, write done in data phase
   assign addr_ok = hsel && hready && (htrans == rtimer_pkg::HTRANS_NONSEQ);
   assign wr_now = wr_pend_r;
   assign wd = hwdata[7:0];
   assign wr_ctrl = wr_now && hit(wr_addr_r, rtimer_pkg::OFF_CTRL);
   assign wr_os = wr_now && hit(wr_addr_r, rtimer_pkg::OFF_OSCTRL) &&
                  os_mode;
   assign wr_pre = wr_now && hit(wr_addr_r, rtimer_pkg::OFF_PRE);
   assign wr_sec = wr_now && hit(wr_addr_r, rtimer_pkg::OFF_SEC);
   assign wr_pri = wr_now && hit(wr_addr_r, rtimer_pkg::OFF_PRI);
   assign fstop = wr_ctrl && wd[rtimer_pkg::CTRL_FSTOP];

   // count source selection
   always_comb begin
      unique case (src_sel)
         rtimer_pkg::S_DIV1: src_tick = 1'b1;
         rtimer_pkg::S_DIV8: src_tick = (div_r == rtimer_pkg::DIV8_LAST);
         rtimer_pkg::S_COMP: src_tick = ra_underflow;
         rtimer_pkg::S_DIV2: src_tick = div_r[0];
      endcase
      if (mode_r[rtimer_pkg::SRC_CUT]) begin
         src_tick = 1'b0;
      end
   end

   // counting runs with start set; one-shot modes also need a trigger
   assign run = start_r && (!os_mode || os_active_r);
   // prescaler underflows on the step after zero
   assign pre_uf = run && src_tick && !pre_pend_r && (pre_cnt_r == 8'h00);
   assign tmr_uf = pre_uf && !tmr_pend_r && (tmr_cnt_r == 8'h00);
   assign trig = os_mode && start_r && !os_active_r &&
      ((wr_os && wd[rtimer_pkg::OS_START]) ||
       (io_r[rtimer_pkg::IO_TRIG_EN] && trig_sync_r[1] && !trig_sync_r[2]));
   assign os_stop = wr_os && wd[rtimer_pkg::OS_STOP];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_r <= 3'h0;
         trig_sync_r <= 3'h0;
      end else begin
         div_r <= div_r + 3'h1;
         trig_sync_r <= {trig_sync_r[1:0], external_trigger_pin};
      end
   end

   // bus slave: zero wait states, okay response
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         rdata_r <= 32'h0;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_r <= addr_ok && hwrite;
         if (addr_ok) begin
            wr_addr_r <= haddr[7:0];
         end
         if (addr_ok && !hwrite) begin
            unique case (haddr[7:0])
               rtimer_pkg::OFF_CTRL:
                  rdata_r <= {29'h0, 1'b0, status_r, start_r};
               rtimer_pkg::OFF_OSCTRL:
                  rdata_r <= {29'h0, os_active_r, 2'h0};
               rtimer_pkg::OFF_IOCTRL: rdata_r <= {24'h0, io_r};
               rtimer_pkg::OFF_MODE: rdata_r <= {24'h0, mode_r};
               rtimer_pkg::OFF_PRE: begin
                  rdata_r <= {24'h0, pre_cnt_r};
               end
               rtimer_pkg::OFF_SEC: rdata_r <= {24'h0, sec_rl_r};
               // current count in either phase
               rtimer_pkg::OFF_PRI: begin
                  rdata_r <= {24'h0, tmr_cnt_r};
               end
               default: rdata_r <= 32'h0;
            endcase
         end
      end
   end
   assign hrdata = rdata_r;

   // control state: start, status, one-shot, mode, io
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         start_r <= 1'b0;
         status_r <= 1'b0;
         os_active_r <= 1'b0;
         io_r <= 8'h00;
         mode_r <= 8'h00;
      end else begin
         if (fstop) begin
            start_r <= 1'b0;
         end else if (wr_ctrl) begin
            start_r <= wd[rtimer_pkg::CTRL_START];
         end
         if (fstop || !start_r || !os_mode) begin
            os_active_r <= 1'b0;
         end else if (trig) begin
            os_active_r <= 1'b1;
         end else if (os_stop || (tmr_uf && !sec_phase_r)) begin
            os_active_r <= 1'b0;
         end
         if (fstop) begin
            status_r <= 1'b0;
         end else begin
            status_r <= start_r && (!os_mode || os_active_r);
         end
         if (wr_now && hit(wr_addr_r, rtimer_pkg::OFF_IOCTRL)) begin
            io_r <= wd;
         end
         if (wr_now && hit(wr_addr_r, rtimer_pkg::OFF_MODE)) begin
            mode_r <= wd;
         end
      end
   end

   // reload registers and working counters
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_rl_r <= rtimer_pkg::CNT_RST;
         pre_cnt_r <= rtimer_pkg::CNT_RST;
         sec_rl_r <= rtimer_pkg::CNT_RST;
         pri_rl_r <= rtimer_pkg::CNT_RST;
         tmr_cnt_r <= rtimer_pkg::CNT_RST;
         pre_pend_r <= 1'b0;
         tmr_pend_r <= 1'b0;
         sec_phase_r <= 1'b0;
      end else if (fstop) begin
         pre_rl_r <= rtimer_pkg::CNT_RST;
         pre_cnt_r <= rtimer_pkg::CNT_RST;
         sec_rl_r <= rtimer_pkg::CNT_RST;
         pri_rl_r <= rtimer_pkg::CNT_RST;
         tmr_cnt_r <= rtimer_pkg::CNT_RST;
         pre_pend_r <= 1'b0;
         tmr_pend_r <= 1'b0;
         sec_phase_r <= 1'b0;
      end else begin
         // prescaler stage
         if (run && src_tick) begin
            if (pre_pend_r) begin
               pre_cnt_r <= pre_rl_r;
               pre_pend_r <= 1'b0;
            end else if (pre_uf) begin
               pre_cnt_r <= pre_rl_r;
            end else begin
               pre_cnt_r <= pre_cnt_r - 8'h01;
            end
         end
         // timer stage, stepped by prescaler underflow
         if (trig && op_mode == rtimer_pkg::M_WAIT) begin
            sec_phase_r <= 1'b1;
            tmr_cnt_r <= sec_rl_r;
         end else if (!start_r || !os_active_r && os_mode) begin
            // stopped one-shot modes sit at the primary reload
            sec_phase_r <= 1'b0;
            if (os_mode && !wr_pri) begin
               tmr_cnt_r <= pri_rl_r;
            end
         end else if (pre_uf) begin
            if (tmr_pend_r) begin
               tmr_cnt_r <= pri_rl_r;
               tmr_pend_r <= 1'b0;
            end else if (tmr_uf) begin
               if (wave_mode && !sec_phase_r) begin
                  sec_phase_r <= 1'b1;
                  tmr_cnt_r <= sec_rl_r;
               end else begin
                  sec_phase_r <= 1'b0;
                  tmr_cnt_r <= pri_rl_r;
               end
            end else begin
               tmr_cnt_r <= tmr_cnt_r - 8'h01;
            end
         end
         // register writes
         if (wr_pre) begin
            pre_rl_r <= wd;
            if (!status_r) begin
               pre_cnt_r <= wd;
            end else if (!mode_r[rtimer_pkg::MODE_WRC]) begin
               pre_pend_r <= 1'b1;
            end
         end
         if (wr_sec) begin
            sec_rl_r <= wd;
         end
         if (wr_pri) begin
            pri_rl_r <= wd;
            if (!status_r) begin
               tmr_cnt_r <= wd;
            end else if (!mode_r[rtimer_pkg::MODE_WRC]) begin
               tmr_pend_r <= 1'b1;
            end
         end
      end
   end

   // interrupt and output pin
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_r <= 1'b0;
         out_o_r <= 1'b0;
         out_oe_r <= 1'b0;
      end else begin
         if (timer_mode) begin
            irq_r <= tmr_uf;
            out_o_r <= io_r[rtimer_pkg::IO_PORT_VAL];
            out_oe_r <= io_r[rtimer_pkg::IO_PORT_OE];
         end else if (wave_mode) begin
            irq_r <= tmr_uf && sec_phase_r;
            out_o_r <= (run && sec_phase_r) ^ io_r[rtimer_pkg::IO_LEVEL];
            out_oe_r <= 1'b1;
         end else begin
            irq_r <= tmr_uf && !sec_phase_r;
            out_o_r <= (os_active_r && !sec_phase_r) ^
                       io_r[rtimer_pkg::IO_LEVEL];
            out_oe_r <= 1'b1;
         end
      end
   end
   assign timer_irq = irq_r;
   assign timer_output_pin_o = out_o_r;
   assign timer_output_pin_oe = out_oe_r;
endmodule

// ### tb/reload_timer_assertions.sv
// checker for reload_timer bus answers, start readback and requests
// assumes one ahb-lite master with hready tied to hreadyout
`timescale 1ns/1ns
module reload_timer_chk (
   input wire logic hclk, // clock
   input wire logic hresetn, // reset, active low
   input wire logic hsel, // select
   input wire logic [31:0] haddr, // address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write
   input wire logic [2:0] hsize, // size
   input wire logic hready, // ready in
   input wire logic [31:0] hwdata, // write data
   input wire logic [31:0] hrdata, // read data
   input wire logic hreadyout, // ready out
   input wire logic hresp, // response
   input wire logic ra_underflow, // companion underflow
   input wire logic external_trigger_pin, // trigger
   input wire logic timer_output_pin_o, // pin level
   input wire logic timer_output_pin_oe, // pin enable
   input wire logic timer_irq // request
);
   logic tk, rdt, wp_r, run_r, oe_r;
   logic [7:0] wa_r;
   logic [3:0] idle_r;
   assign tk = hsel && hready && htrans == rtimer_pkg::HTRANS_NONSEQ;
   assign rdt = tk && !hwrite;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_r <= 1'b0;
         wa_r <= 8'h00;
      end else if (hready) begin
         wp_r <= tk && hwrite;
         wa_r <= haddr[7:0];
      end
   end
   // start bit as software last wrote it, forced stop wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_r <= 1'b0;
         oe_r <= 1'b0;
      end else if (wp_r && wa_r == rtimer_pkg::OFF_CTRL) begin
         run_r <= hwdata[0] & ~hwdata[2];
      end else if (wp_r && wa_r == rtimer_pkg::OFF_IOCTRL) begin
         oe_r <= hwdata[2];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idle_r <= 4'h0;
      end else if (run_r) begin
         idle_r <= 4'h0;
      end else if (idle_r != 4'hf) begin
         idle_r <= idle_r + 4'h1;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_okay; tk |=> hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("bad response");
   property p_ready; tk |=> hreadyout; endproperty
   a_ready: assert property (p_ready) else $error("wait state seen");
   property p_upper; rdt |=> hrdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper)
      else $error("upper bits set");
   property p_unmapped; rdt && haddr[7:0] > 8'h18 |=> hrdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped not 0");
   property p_fstop_rd; rdt && haddr[7:0] == rtimer_pkg::OFF_CTRL
      |=> !hrdata[2]; endproperty
   a_fstop_rd: assert property (p_fstop_rd)
      else $error("stop bit read");
   property p_start_rb; rdt && haddr[7:0] == rtimer_pkg::OFF_CTRL
      |=> hrdata[0] == $past(run_r); endproperty
   a_start_rb: assert property (p_start_rb)
      else $error("start readback");
   property p_irq_stop; timer_irq |-> idle_r < 4'h6; endproperty
   a_irq_stop: assert property (p_irq_stop)
      else $error("irq while off");
   property p_port_oe; wp_r && wa_r == rtimer_pkg::OFF_IOCTRL
      |-> ##[1:2] timer_output_pin_oe == oe_r; endproperty
   a_port_oe: assert property (p_port_oe)
      else $error("port enable");
endmodule
bind reload_timer reload_timer_chk i_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .ra_underflow(ra_underflow),
   .external_trigger_pin(external_trigger_pin),
   .timer_output_pin_o(timer_output_pin_o),
   .timer_output_pin_oe(timer_output_pin_oe), .timer_irq(timer_irq));

// ### tb/reload_timer_tb_top.sv
// self-checking bench for reload_timer: registers, periods, stops
// assumes the checker binds itself; bus master is ahb-lite
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
   err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
   end end
module reload_timer_tb_top;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic ra_underflow = 1'b0, trig = 1'b0;
   logic hreadyout, hresp, pin_o, pin_oe, irq;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [7:0] ra [6] = '{8'h10, 8'h14, 8'h18, 8'h00, 8'h0c, 8'h1c};
   logic [31:0] rv [6] = '{32'hff, 32'hff, 32'hff, 32'h0, 32'h0, 32'h0};
   logic [1:0] src [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
   int dvt [4] = '{1, 8, 0, 2};
   int err_total = 0, checks_done = 0, pre_m, pri_m, dv, g, k = 3, uc = 0;
   int exp_gap;
   always #4 hclk = ~hclk;
   // companion underflow: one-cycle pulse every k cycles
   always @(posedge hclk) begin
      uc <= (uc >= k - 1) ? 0 : uc + 1;
      ra_underflow <= (uc == 0);
   end
   reload_timer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ra_underflow(ra_underflow),
      .external_trigger_pin(trig), .timer_output_pin_o(pin_o),
      .timer_output_pin_oe(pin_oe), .timer_irq(irq));
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= rtimer_pkg::HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic sweep(input int n);
      for (int i = 0; i < n; i++) begin
         bus(1'b0, ra[i], 32'h0);
         `CHK(rd, rv[i])
      end
   endtask
   // cycles between two timer requests, after one partial period
   task automatic gap(output int n);
      n = 0;
      do @(posedge hclk); while (irq !== 1'b1);
      do begin @(posedge hclk); n++; end while (irq !== 1'b1);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #400000;
      err_total++;
      complete_run();
   end
   initial begin
      pre_m = $urandom(55);
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b1, 8'h1c, 32'h5a);
      sweep(6);
      bus(1'b1, 8'h14, 32'h3c);
      bus(1'b1, 8'h18, 32'hff);
      bus(1'b0, 8'h14, 32'h0);
      `CHK(rd, 32'h3c)
      $display("test reset_values done");
      for (int s = 0; s < 4; s++) begin
         pre_m = $urandom % 4;
         pri_m = 1 + $urandom % 5;
         k = 2 + $urandom % 3;
         dv = (s == 2) ? k : dvt[s];
         bus(1'b1, 8'h0c, {26'h0, src[s], 4'h0});
         bus(1'b1, 8'h10, 32'(pre_m));
         bus(1'b1, 8'h18, 32'(pri_m));
         bus(1'b0, 8'h10, 32'h0);
         `CHK(rd, 32'(pre_m))
         bus(1'b1, 8'h00, 32'h1);
         exp_gap = dv * (pre_m + 1) * (pri_m + 1);
         repeat (2) begin
            gap(g);
            `CHK(g, exp_gap)
         end
         bus(1'b0, 8'h18, 32'h0);
         `CHK(rd <= 32'(pri_m), 1'b1)
         bus(1'b1, 8'h00, 32'h0);
         repeat (4) @(posedge hclk);
         bus(1'b0, 8'h00, 32'h0);
         `CHK(rd, 32'h0)
         g = 0;
         repeat (dv * 64) @(posedge hclk) if (irq !== 1'b0) g++;
         `CHK(g, 0)
      end
      $display("test sources done");
      for (int w = 0; w < 2; w++) begin
         bus(1'b1, 8'h0c, 32'(w << 3));
         bus(1'b1, 8'h10, 32'h1);
         bus(1'b1, 8'h18, 32'h3);
         bus(1'b1, 8'h00, 32'h1);
         gap(g);
         `CHK(g, 8)
         pri_m = 4 + w;
         bus(1'b1, 8'h18, 32'(pri_m));
         gap(g);
         `CHK(g, 2 * (pri_m + 1))
         if (w == 0) bus(1'b1, 8'h00, 32'h0);
      end
      bus(1'b1, 8'h00, 32'h5);
      sweep(4);
      $display("test write_control_and_forced_stop done");
      bus(1'b1, 8'h08, 32'h6);
      repeat (2) @(posedge hclk);
      `CHK(pin_oe, 1'b1)
      `CHK(pin_o, 1'b1)
      bus(1'b1, 8'h04, 32'h1);
      bus(1'b0, 8'h04, 32'h0);
      `CHK(rd[2], 1'b0)
      bus(1'b1, 8'h0c, 32'h0a);
      bus(1'b1, 8'h00, 32'h1);
      repeat (4) @(posedge hclk);
      bus(1'b0, 8'h00, 32'h0);
      `CHK(rd[1], 1'b0)
      bus(1'b1, 8'h04, 32'h1);
      repeat (4) @(posedge hclk);
      bus(1'b0, 8'h00, 32'h0);
      `CHK(rd[1], 1'b1)
      bus(1'b1, 8'h00, 32'h4);
      bus(1'b0, 8'h04, 32'h0);
      `CHK(rd[2], 1'b0)
      $display("test port_and_oneshot done");
      bus(1'b1, 8'h0c, 32'h09);
      bus(1'b1, 8'h10, 32'h0);
      bus(1'b1, 8'h14, 32'h2);
      bus(1'b1, 8'h18, 32'h1);
      bus(1'b1, 8'h00, 32'h1);
      gap(g);
      `CHK(g, (0 + 1) * ((1 + 1) + (2 + 1)))
      bus(1'b1, 8'h00, 32'h4);
      $display("test waveform done");
      bus(1'b1, 8'h0c, 32'h0b);
      bus(1'b1, 8'h08, 32'hc);
      bus(1'b1, 8'h10, 32'h0);
      bus(1'b1, 8'h14, 32'h8);
      bus(1'b1, 8'h18, 32'h8);
      bus(1'b1, 8'h00, 32'h1);
      trig <= 1'b1;
      repeat (4) @(posedge hclk);
      bus(1'b0, 8'h00, 32'h0);
      `CHK(rd[1], 1'b1)
      g = 0;
      repeat (40) @(posedge hclk) if (irq === 1'b1) g++;
      `CHK(g, 1)
      bus(1'b0, 8'h00, 32'h0);
      `CHK(rd[1], 1'b0)
      trig <= 1'b0;
      $display("test wait_oneshot done");
      complete_run();
   end
endmodule
